// File: rtl/ctr_defines.svh
// register offsets, bit positions and reset values of the codec/touch control bank
`ifndef CTR_DEFINES_SVH
`define CTR_DEFINES_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define CTR_ADDR_RISE_EN      4'h2
`define CTR_ADDR_FALL_EN      4'h3
`define CTR_ADDR_IRQ          4'h4
`define CTR_ADDR_TEL_A        4'h5
`define CTR_ADDR_TEL_B        4'h6
`define CTR_ADDR_AUD_A        4'h7
`define CTR_ADDR_AUD_B        4'h8
`define CTR_ADDR_TOUCH        4'h9

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CTR_BIT_CLIP_TEL      14
`define CTR_BIT_CLIP_AUD      15
`define CTR_DIV_MSB           6
`define CTR_DIV_LSB           0
`define CTR_BIT_TEL_GAIN      7
`define CTR_BIT_TEL_VOICE     3
`define CTR_BIT_TEL_STICKY    4
`define CTR_BIT_TEL_ATTEN     6
`define CTR_BIT_TEL_SIDE      11
`define CTR_BIT_MUTE          13
`define CTR_BIT_IN_ON         14
`define CTR_BIT_OUT_ON        15
`define CTR_AUDIO_INPUT_GAIN_MSB      11
`define CTR_AUDIO_INPUT_GAIN_LSB      7
`define CTR_AUDIO_OUTPUT_ATTEN_MSB       4
`define CTR_AUDIO_OUTPUT_ATTEN_LSB       0
`define CTR_BIT_AUD_STICKY    6
`define CTR_BIT_AUDIO_LOOPBACK      8
`define CTR_PLATE_MSB         3
`define CTR_PLATE_LSB         0

// ----------------------------------------------------------------
// reset values and synchroniser stage count
// ----------------------------------------------------------------
`define CTR_TELECOM_RATE_DIVISOR_RST       7'h10
`define CTR_AUDIO_RATE_DIVISOR_RST       7'h09
`define CTR_SYNC_STAGES       2

`endif

// File: rtl/ctr_pkg.sv
// types shared by the codec/touch control bank
package ctr_pkg;

    // ----------------------------------------------------------------
    // register port request
    // ----------------------------------------------------------------
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [3:0]  addr;
        logic [15:0] wdata;
    } ctr_reg_req_t;

    // ----------------------------------------------------------------
    // control and clip status fields
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [6:0] telecom_rate_divisor;
        logic       telecom_extra_gain;
        logic       telecom_input_atten;
        logic       telecom_voice_filter_on;
        logic       sidetone_suppress_on;
        logic       telecom_output_mute;
        logic       telecom_input_path_on;
        logic       telecom_output_path_on;
    } ctr_tel_ctrl_t;

    typedef struct packed {
        logic [6:0] audio_rate_divisor;
        logic [4:0] audio_input_gain;
        logic [4:0] audio_output_atten;
        logic       audio_loopback;
        logic       audio_output_mute;
        logic       audio_input_path_on;
        logic       audio_output_path_on;
    } ctr_aud_ctrl_t;

    typedef struct packed {
        logic plate_plus_y_power;
        logic plate_minus_y_power;
        logic plate_plus_x_power;
        logic plate_minus_x_power;
    } ctr_plate_t;

    typedef struct packed {
        logic audio_clip_irq_status;
        logic telecom_clip_irq_status;
        logic audio_clip_sticky;
        logic telecom_clip_sticky;
    } ctr_clip_t;

endpackage : ctr_pkg

// File: rtl/ctr_sync_edge.sv
// two-flop synchroniser for a clip level with edge pulses
`timescale 1ns/100ps
`default_nettype none
module ctr_sync_edge #(
    parameter int STAGES = 2
) (
    // clock and control
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic ce,
    // asynchronous input
    input  wire logic async_in,
    // synchronised level and edges
    output logic      level,
    output logic      rise,
    output logic      fall
);
    logic [STAGES-1:0] chain;
    logic              prev;

    if (STAGES < 2) begin : g_chk
        $error("ctr_sync_edge needs at least two stages");
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            chain <= '0;
            prev  <= 1'b0;
        end else if (ce) begin
            chain <= {chain[STAGES-2:0], async_in};
            prev  <= chain[STAGES-1];
        end
    end

    assign level = chain[STAGES-1];
    assign rise  = chain[STAGES-1] & ~prev;
    assign fall  = ~chain[STAGES-1] & prev;
endmodule : ctr_sync_edge
`default_nettype wire

// File: rtl/ctr_flag.sv
// status flag set by hardware, cleared by a written 0-to-1 change
`timescale 1ns/100ps
`default_nettype none
module ctr_flag (
    // clock and control
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic ce,
    // hardware set
    input  wire logic set,
    // software write of the clear bit
    input  wire logic wr,
    input  wire logic wbit,
    // flag
    output logic      flag
);
    logic last_wr;
    logic clr;

    // clear only on a change from the previously written value
    assign clr = wr & wbit & ~last_wr;

    always_ff @(posedge clk) begin
        if (rst) begin
            last_wr <= 1'b0;
        end else if (ce && wr) begin
            last_wr <= wbit;
        end
    end

    // set wins over clear
    always_ff @(posedge clk) begin
        if (rst) begin
            flag <= 1'b0;
        end else if (ce) begin
            if (set) begin
                flag <= 1'b1;
            end else if (clr) begin
                flag <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_clear_fires: assert property (@(posedge clk) disable iff (rst)
        ce && clr && !set |=> !flag) else $error("flag not cleared by rising write");
    a_set_wins: assert property (@(posedge clk) disable iff (rst)
        ce && set |=> flag) else $error("flag set lost");
    a_repeat_no_clear: assert property (@(posedge clk) disable iff (rst)
        ce && wr && wbit && last_wr && flag |=> flag) else $error("repeat write cleared");
endmodule : ctr_flag
`default_nettype wire

// File: rtl/ctr_regs.sv
// control register bank for the telecom codec, audio codec and touch plates
`timescale 1ns/100ps
`default_nettype none
`include "ctr_defines.svh"

// Contract
// - rising write to interrupt bit 14 clears telecom clip interrupt; read shows status.
// - rising write to interrupt bit 15 clears audio clip interrupt; read shows status.
// - telecom divisor in bits 0-6, resets to 16; software uses 16..127.
// - telecom A bit 7 enables extra +6dB telecom input gain.
// - telecom B bit 3 enables the voice band filter.
// - telecom B bit 4 reads sticky telecom clip status, held until cleared.
// - rising write to telecom B bit 4 clears the telecom clip status.
// - telecom B bit 6 gives -6dB attenuation and overrides the extra gain.
// - telecom B bit 11 activates sidetone suppression.
// - telecom B bits 13/14/15 mute output, enable input, enable output.
// - audio divisor in bits 0-6, resets to 9; software uses 6..127.
// - audio A bits 7-11 select audio input gain.
// - audio B bits 0-4 select audio output attenuation.
// - audio B bit 6 reads sticky audio clip status, held until cleared.
// - rising write to audio B bit 6 clears the audio clip status.
// - audio B bit 8 puts the audio codec in loopback.
// - audio B bits 13/14/15 mute output, enable input, enable output.
// - touch bits 0-3 power minus-X, plus-X, minus-Y, plus-Y plates.
// - all control fields reset to zero except the two divisors.
// - clip interrupt latches on rising clip edge when rising enable is set.
// - clip interrupt latches on falling clip edge when falling enable is set.
module ctr_regs (
    // clock, reset, enable
    input  wire logic                 CLK,
    input  wire logic                 RESET,
    input  wire logic                 CE,
    // register port
    input  wire ctr_pkg::ctr_reg_req_t REG_REQ,
    output logic [15:0]               REG_RDATA,
    // clip detectors, asynchronous: bit 0 telecom, bit 1 audio
    input  wire logic [1:0]           CLIP_IN,
    // control outputs
    output ctr_pkg::ctr_tel_ctrl_t    TEL_CTRL,
    output logic                      TEL_GAIN_BOOST,
    output ctr_pkg::ctr_aud_ctrl_t    AUD_CTRL,
    output ctr_pkg::ctr_plate_t       PLATE_POWER,
    output ctr_pkg::ctr_clip_t        CLIP_STATUS
);
    import ctr_pkg::*;

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    logic        wr_rise_en;
    logic        wr_fall_en;
    logic        wr_irq;
    logic        wr_tel_a;
    logic        wr_tel_b;
    logic        wr_aud_a;
    logic        wr_aud_b;
    logic        wr_touch;
    logic [15:0] wd;

    assign wd         = REG_REQ.wdata;
    assign wr_rise_en = REG_REQ.wr && REG_REQ.addr == `CTR_ADDR_RISE_EN;
    assign wr_fall_en = REG_REQ.wr && REG_REQ.addr == `CTR_ADDR_FALL_EN;
    assign wr_irq     = REG_REQ.wr && REG_REQ.addr == `CTR_ADDR_IRQ;
    assign wr_tel_a   = REG_REQ.wr && REG_REQ.addr == `CTR_ADDR_TEL_A;
    assign wr_tel_b   = REG_REQ.wr && REG_REQ.addr == `CTR_ADDR_TEL_B;
    assign wr_aud_a   = REG_REQ.wr && REG_REQ.addr == `CTR_ADDR_AUD_A;
    assign wr_aud_b   = REG_REQ.wr && REG_REQ.addr == `CTR_ADDR_AUD_B;
    assign wr_touch   = REG_REQ.wr && REG_REQ.addr == `CTR_ADDR_TOUCH;

    // ----------------------------------------------------------------
    // edge enables
    // ----------------------------------------------------------------
    logic [1:0] rise_en;
    logic [1:0] fall_en;

    always_ff @(posedge CLK) begin
        if (RESET) begin
            rise_en <= 2'h0;
        end else if (CE && wr_rise_en) begin
            rise_en <= wd[`CTR_BIT_CLIP_AUD:`CTR_BIT_CLIP_TEL];
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            fall_en <= 2'h0;
        end else if (CE && wr_fall_en) begin
            fall_en <= wd[`CTR_BIT_CLIP_AUD:`CTR_BIT_CLIP_TEL];
        end
    end

    // ----------------------------------------------------------------
    // telecom control
    // ----------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (RESET) begin
            TEL_CTRL.telecom_rate_divisor <= `CTR_TELECOM_RATE_DIVISOR_RST;
            TEL_CTRL.telecom_extra_gain   <= 1'b0;
        end else if (CE && wr_tel_a) begin
            TEL_CTRL.telecom_rate_divisor <= wd[`CTR_DIV_MSB:`CTR_DIV_LSB];
            TEL_CTRL.telecom_extra_gain   <= wd[`CTR_BIT_TEL_GAIN];
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            TEL_CTRL.telecom_input_atten     <= 1'b0;
            TEL_CTRL.telecom_voice_filter_on <= 1'b0;
            TEL_CTRL.sidetone_suppress_on    <= 1'b0;
            TEL_CTRL.telecom_output_mute     <= 1'b0;
            TEL_CTRL.telecom_input_path_on   <= 1'b0;
            TEL_CTRL.telecom_output_path_on  <= 1'b0;
        end else if (CE && wr_tel_b) begin
            TEL_CTRL.telecom_input_atten     <= wd[`CTR_BIT_TEL_ATTEN];
            TEL_CTRL.telecom_voice_filter_on <= wd[`CTR_BIT_TEL_VOICE];
            TEL_CTRL.sidetone_suppress_on    <= wd[`CTR_BIT_TEL_SIDE];
            TEL_CTRL.telecom_output_mute     <= wd[`CTR_BIT_MUTE];
            TEL_CTRL.telecom_input_path_on   <= wd[`CTR_BIT_IN_ON];
            TEL_CTRL.telecom_output_path_on  <= wd[`CTR_BIT_OUT_ON];
        end
    end

    // attenuation overrides the extra gain
    always_ff @(posedge CLK) begin
        if (RESET) begin
            TEL_GAIN_BOOST <= 1'b0;
        end else if (CE) begin
            TEL_GAIN_BOOST <= TEL_CTRL.telecom_extra_gain
                              & ~TEL_CTRL.telecom_input_atten;
        end
    end

    // ----------------------------------------------------------------
    // audio control
    // ----------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (RESET) begin
            AUD_CTRL.audio_rate_divisor <= `CTR_AUDIO_RATE_DIVISOR_RST;
            AUD_CTRL.audio_input_gain   <= 5'h00;
        end else if (CE && wr_aud_a) begin
            AUD_CTRL.audio_rate_divisor <= wd[`CTR_DIV_MSB:`CTR_DIV_LSB];
            AUD_CTRL.audio_input_gain   <= wd[`CTR_AUDIO_INPUT_GAIN_MSB:`CTR_AUDIO_INPUT_GAIN_LSB];
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            AUD_CTRL.audio_output_atten   <= 5'h00;
            AUD_CTRL.audio_loopback       <= 1'b0;
            AUD_CTRL.audio_output_mute    <= 1'b0;
            AUD_CTRL.audio_input_path_on  <= 1'b0;
            AUD_CTRL.audio_output_path_on <= 1'b0;
        end else if (CE && wr_aud_b) begin
            AUD_CTRL.audio_output_atten   <= wd[`CTR_AUDIO_OUTPUT_ATTEN_MSB:`CTR_AUDIO_OUTPUT_ATTEN_LSB];
            AUD_CTRL.audio_loopback       <= wd[`CTR_BIT_AUDIO_LOOPBACK];
            AUD_CTRL.audio_output_mute    <= wd[`CTR_BIT_MUTE];
            AUD_CTRL.audio_input_path_on  <= wd[`CTR_BIT_IN_ON];
            AUD_CTRL.audio_output_path_on <= wd[`CTR_BIT_OUT_ON];
        end
    end

    // ----------------------------------------------------------------
    // touch plates
    // ----------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (RESET) begin
            PLATE_POWER <= '0;
        end else if (CE && wr_touch) begin
            PLATE_POWER <= wd[`CTR_PLATE_MSB:`CTR_PLATE_LSB];
        end
    end

    // ----------------------------------------------------------------
    // clip channels: 0 telecom, 1 audio
    // ----------------------------------------------------------------
    logic [1:0] clip_level;
    logic [1:0] clip_rise;
    logic [1:0] clip_fall;
    logic [1:0] irq_set;
    logic [1:0] irq_stat;
    logic [1:0] sticky;

    for (genvar ch = 0; ch < 2; ch++) begin : g_ch
        ctr_sync_edge #(
            .STAGES   (`CTR_SYNC_STAGES)
        ) u_sync (
            .clk      (CLK),
            .rst      (RESET),
            .ce       (CE),
            .async_in (CLIP_IN[ch]),
            .level    (clip_level[ch]),
            .rise     (clip_rise[ch]),
            .fall     (clip_fall[ch])
        );

        // edge interrupt gated by its enables
        assign irq_set[ch] = (clip_rise[ch] & rise_en[ch])
                           | (clip_fall[ch] & fall_en[ch]);

        ctr_flag u_irq (
            .clk  (CLK),
            .rst  (RESET),
            .ce   (CE),
            .set  (irq_set[ch]),
            .wr   (wr_irq),
            .wbit (wd[`CTR_BIT_CLIP_TEL + ch]),
            .flag (irq_stat[ch])
        );

        // sticky detection status
        ctr_flag u_sticky (
            .clk  (CLK),
            .rst  (RESET),
            .ce   (CE),
            .set  (clip_level[ch]),
            .wr   (ch == 0 ? wr_tel_b : wr_aud_b),
            .wbit (ch == 0 ? wd[`CTR_BIT_TEL_STICKY] : wd[`CTR_BIT_AUD_STICKY]),
            .flag (sticky[ch])
        );
    end

    assign CLIP_STATUS = {irq_stat[1], irq_stat[0], sticky[1], sticky[0]};

    // ----------------------------------------------------------------
    // read back
    // ----------------------------------------------------------------
    logic [15:0] next_rdata;

    always_comb begin
        next_rdata = 16'h0000;
        case (REG_REQ.addr)
            `CTR_ADDR_RISE_EN: begin
                next_rdata[`CTR_BIT_CLIP_AUD:`CTR_BIT_CLIP_TEL] = rise_en;
            end
            `CTR_ADDR_FALL_EN: begin
                next_rdata[`CTR_BIT_CLIP_AUD:`CTR_BIT_CLIP_TEL] = fall_en;
            end
            `CTR_ADDR_IRQ: begin
                next_rdata[`CTR_BIT_CLIP_AUD:`CTR_BIT_CLIP_TEL] = irq_stat;
            end
            `CTR_ADDR_TEL_A: begin
                next_rdata[`CTR_DIV_MSB:`CTR_DIV_LSB] = TEL_CTRL.telecom_rate_divisor;
                next_rdata[`CTR_BIT_TEL_GAIN]         = TEL_CTRL.telecom_extra_gain;
            end
            `CTR_ADDR_TEL_B: begin
                next_rdata[`CTR_BIT_TEL_VOICE]  = TEL_CTRL.telecom_voice_filter_on;
                next_rdata[`CTR_BIT_TEL_STICKY] = sticky[0];
                next_rdata[`CTR_BIT_TEL_ATTEN]  = TEL_CTRL.telecom_input_atten;
                next_rdata[`CTR_BIT_TEL_SIDE]   = TEL_CTRL.sidetone_suppress_on;
                next_rdata[`CTR_BIT_MUTE]       = TEL_CTRL.telecom_output_mute;
                next_rdata[`CTR_BIT_IN_ON]      = TEL_CTRL.telecom_input_path_on;
                next_rdata[`CTR_BIT_OUT_ON]     = TEL_CTRL.telecom_output_path_on;
            end
            `CTR_ADDR_AUD_A: begin
                next_rdata[`CTR_DIV_MSB:`CTR_DIV_LSB] = AUD_CTRL.audio_rate_divisor;
                next_rdata[`CTR_AUDIO_INPUT_GAIN_MSB:`CTR_AUDIO_INPUT_GAIN_LSB] = AUD_CTRL.audio_input_gain;
            end
            `CTR_ADDR_AUD_B: begin
                next_rdata[`CTR_AUDIO_OUTPUT_ATTEN_MSB:`CTR_AUDIO_OUTPUT_ATTEN_LSB] = AUD_CTRL.audio_output_atten;
                next_rdata[`CTR_BIT_AUD_STICKY] = sticky[1];
                next_rdata[`CTR_BIT_AUDIO_LOOPBACK]   = AUD_CTRL.audio_loopback;
                next_rdata[`CTR_BIT_MUTE]       = AUD_CTRL.audio_output_mute;
                next_rdata[`CTR_BIT_IN_ON]      = AUD_CTRL.audio_input_path_on;
                next_rdata[`CTR_BIT_OUT_ON]     = AUD_CTRL.audio_output_path_on;
            end
            `CTR_ADDR_TOUCH: begin
                next_rdata[`CTR_PLATE_MSB:`CTR_PLATE_LSB] = PLATE_POWER;
            end
            default: begin
                next_rdata = 16'h0000;
            end
        endcase
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            REG_RDATA <= 16'h0000;
        end else if (CE && REG_REQ.rd) begin
            REG_RDATA <= next_rdata;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RESET);

    sequence s_tel_b_write;
        CE && wr_tel_b;
    endsequence

    sequence s_clip_tel_rise_armed;
        CE && clip_rise[0] && rise_en[0];
    endsequence

    a_reset_values: assert property (disable iff (1'b0)
        RESET |=> TEL_CTRL.telecom_rate_divisor == `CTR_TELECOM_RATE_DIVISOR_RST
                  && AUD_CTRL.audio_rate_divisor == `CTR_AUDIO_RATE_DIVISOR_RST
                  && PLATE_POWER == 4'h0 && !TEL_CTRL.telecom_extra_gain
                  && !AUD_CTRL.audio_loopback) else $error("bad reset values");
    a_atten_override: assert property (
        CE && TEL_CTRL.telecom_input_atten |=> !TEL_GAIN_BOOST)
        else $error("attenuation did not override gain");
    a_boost_follows: assert property (
        CE && TEL_CTRL.telecom_extra_gain && !TEL_CTRL.telecom_input_atten
        |=> TEL_GAIN_BOOST) else $error("extra gain not applied");
    a_tel_b_fields: assert property (
        s_tel_b_write |=> TEL_CTRL.telecom_output_path_on == $past(wd[15])
                          && TEL_CTRL.sidetone_suppress_on == $past(wd[11]))
        else $error("telecom B write not taken");
    a_plate_write: assert property (
        CE && wr_touch |=> PLATE_POWER == $past(wd[3:0]))
        else $error("plate power not written");
    a_sticky_holds: assert property (
        CLIP_STATUS.telecom_clip_sticky && !wr_tel_b |=> CLIP_STATUS.telecom_clip_sticky)
        else $error("telecom sticky dropped");
    a_aud_sticky_holds: assert property (
        CLIP_STATUS.audio_clip_sticky && !wr_aud_b |=> CLIP_STATUS.audio_clip_sticky)
        else $error("audio sticky dropped");
    a_irq_rise_latch: assert property (
        s_clip_tel_rise_armed |=> CLIP_STATUS.telecom_clip_irq_status)
        else $error("rising clip not latched");
    a_irq_fall_latch: assert property (
        CE && clip_fall[1] && fall_en[1] |=> CLIP_STATUS.audio_clip_irq_status)
        else $error("falling clip not latched");
    a_irq_no_spurious: assert property (
        CE && !irq_set[0] && !irq_stat[0] |=> !irq_stat[0])
        else $error("telecom interrupt set without enabled edge");
    a_reserved_zero: assert property (
        CE && REG_REQ.rd && REG_REQ.addr == `CTR_ADDR_TEL_A |=> REG_RDATA[15:8] == 8'h00)
        else $error("reserved bits read nonzero");
    a_tel_a_fields: assert property (
        CE && wr_tel_a |=> TEL_CTRL.telecom_rate_divisor == $past(wd[6:0])
                           && TEL_CTRL.telecom_extra_gain == $past(wd[7]))
        else $error("telecom A write not taken");
    a_aud_a_fields: assert property (
        CE && wr_aud_a |=> AUD_CTRL.audio_rate_divisor == $past(wd[6:0])
                           && AUD_CTRL.audio_input_gain == $past(wd[11:7]))
        else $error("audio A write not taken");
    a_aud_b_fields: assert property (
        CE && wr_aud_b |=> AUD_CTRL.audio_output_atten == $past(wd[4:0])
                           && AUD_CTRL.audio_loopback == $past(wd[8])
                           && AUD_CTRL.audio_output_mute == $past(wd[13]))
        else $error("audio B write not taken");
    a_voice_filter: assert property (
        s_tel_b_write |=> TEL_CTRL.telecom_voice_filter_on == $past(wd[3]))
        else $error("voice filter write not taken");
    a_irq_readback: assert property (
        CE && REG_REQ.rd && REG_REQ.addr == `CTR_ADDR_IRQ
        |=> REG_RDATA == {$past(irq_stat), 14'h0000})
        else $error("interrupt status read wrong");
endmodule : ctr_regs
`default_nettype wire

// File: test/ctr_host_model.sv
// system controller model driving the register port
`timescale 1ns/100ps
`default_nettype none
module ctr_host_model (
    // clock
    input  wire logic             clk,
    // register port
    output var ctr_pkg::ctr_reg_req_t req,
    input  wire logic [15:0]      rdata
);
    import ctr_pkg::*;
    logic [15:0] rd_val;
    initial req = '0;
    // one word per access, held over the taking edge, then released
    task automatic acc(input logic w, input logic [3:0] a, input logic [15:0] d);
        req <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge clk);
        req <= '0;
        @(posedge clk);
        rd_val = rdata;
    endtask : acc
endmodule : ctr_host_model
`default_nettype wire

// File: test/tb.sv
// self-checking bench for the codec/touch control bank
`timescale 1ns/100ps
`default_nettype none
module tb;
    import ctr_pkg::*;
    logic          CLK;
    logic          RESET;
    logic          CE;
    logic [1:0]    CLIP_IN;
    ctr_reg_req_t  REG_REQ;
    logic [15:0]   REG_RDATA;
    ctr_tel_ctrl_t TEL_CTRL;
    logic          TEL_GAIN_BOOST;
    ctr_aud_ctrl_t AUD_CTRL;
    ctr_plate_t    PLATE_POWER;
    ctr_clip_t     CLIP_STATUS;
    int            n_mismatch;
    int            cmp_count;
    ctr_regs i_dut (.CLK(CLK), .RESET(RESET), .CE(CE), .REG_REQ(REG_REQ),
        .REG_RDATA(REG_RDATA), .CLIP_IN(CLIP_IN), .TEL_CTRL(TEL_CTRL),
        .TEL_GAIN_BOOST(TEL_GAIN_BOOST), .AUD_CTRL(AUD_CTRL),
        .PLATE_POWER(PLATE_POWER), .CLIP_STATUS(CLIP_STATUS));
    ctr_host_model host (.clk(CLK), .req(REG_REQ), .rdata(REG_RDATA));
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        host.acc(1'b0, a, 16'h0000);
        check(host.rd_val, exp);
    endtask : rd
    task automatic summarize();
        $display("compares=%0d mismatches=%0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : summarize
    task automatic t_reset();
        rd(4'h5, 16'h0010);
        rd(4'h7, 16'h0009);
        rd(4'h6, 16'h0000);
        rd(4'h8, 16'h0000);
        rd(4'h9, 16'h0000);
        rd(4'h4, 16'h0000);
        rd(4'hF, 16'h0000);
    endtask : t_reset
    task automatic t_fields();
        host.acc(1'b1, 4'h5, 16'hFFFF);
        host.acc(1'b1, 4'h6, 16'hFFFF);
        rd(4'h5, 16'h00FF);
        rd(4'h6, 16'hE848);
        check({2'b00, TEL_CTRL}, 16'h3FFF);
        check(TEL_GAIN_BOOST, 16'h0000);
        host.acc(1'b1, 4'h6, 16'h0000);
        rd(4'h6, 16'h0000);
        check(TEL_GAIN_BOOST, 16'h0001);
        host.acc(1'b1, 4'h7, 16'hFFFF);
        host.acc(1'b1, 4'h8, 16'hFFFF);
        rd(4'h7, 16'h0FFF);
        rd(4'h8, 16'hE11F);
        check(AUD_CTRL[15:0], 16'hFFFF);
        host.acc(1'b1, 4'h8, 16'h0000);
        host.acc(1'b1, 4'h5, 16'h0010);
        host.acc(1'b1, 4'h7, 16'h0006);
        rd(4'h5, 16'h0010);
        rd(4'h7, 16'h0006);
        for (int i = 0; i < 4; i++) begin
            host.acc(1'b1, 4'h9, 16'h0001 << i);
            check(PLATE_POWER, 16'h0001 << i);
        end
        rd(4'h9, 16'h0008);
    endtask : t_fields
    task automatic t_clip();
        host.acc(1'b1, 4'h2, 16'h4000);
        host.acc(1'b1, 4'h3, 16'h8000);
        CLIP_IN <= 2'b11;
        repeat (4) @(posedge CLK);
        check(CLIP_STATUS, 16'h0007);
        CLIP_IN <= 2'b00;
        repeat (4) @(posedge CLK);
        check(CLIP_STATUS, 16'h000F);
        rd(4'h4, 16'hC000);
        rd(4'h6, 16'h0010);
        rd(4'h8, 16'h0040);
        host.acc(1'b1, 4'h4, 16'h4000);
        rd(4'h4, 16'h8000);
        host.acc(1'b1, 4'h4, 16'hC000);
        rd(4'h4, 16'h0000);
        CLIP_IN <= 2'b01;
        repeat (4) @(posedge CLK);
        host.acc(1'b1, 4'h4, 16'hC000);
        rd(4'h4, 16'h4000);
        CLIP_IN <= 2'b00;
        repeat (4) @(posedge CLK);
        host.acc(1'b1, 4'h6, 16'h0010);
        rd(4'h6, 16'h0000);
        check(CLIP_STATUS, 16'h0006);
        host.acc(1'b1, 4'h8, 16'h0040);
        rd(4'h8, 16'h0000);
    endtask : t_clip
    task automatic t_ce();
        CE <= 1'b0;
        host.acc(1'b1, 4'h9, 16'h000F);
        check(PLATE_POWER, 16'h0008);
        CE <= 1'b1;
        rd(4'h9, 16'h0008);
    endtask : t_ce
    initial begin
        CLK = 1'b0;
        forever #10 CLK = ~CLK;
    end
    initial begin
        RESET = 1'b1;
        CE = 1'b1;
        CLIP_IN = 2'b00;
        n_mismatch = 0;
        cmp_count = 0;
        repeat (4) @(posedge CLK);
        RESET <= 1'b0;
        @(posedge CLK);
        t_reset();
        t_fields();
        t_clip();
        t_ce();
        RESET <= 1'b1;
        @(posedge CLK);
        RESET <= 1'b0;
        @(posedge CLK);
        t_reset();
        summarize();
    end
endmodule : tb
`default_nettype wire
